// File: core/prhg_pkg.sv
// What this block does
// - at start, test entropy source for total failure; on failure, output nothing.
// - on failure in operation, drop every octet using raw bits after it.
// - run online statistical test at start-up and throughout operation.
// - withhold output until start-up online test passes and whenever it fails.
// - online test runs continuously or periodically; software selects one.
// - random data is delivered to software as 8-bit octets.
// - hardware total-failure self-test runs only when software starts it.
// - self-test outcome reported as one pass or fail bit in a register.
// - internal bits must average above 0.997 bits entropy each, 7.976 per octet.
package prhg_pkg;
    localparam logic [7:0]  REG_CTRL     = 8'h00;
    localparam logic [7:0]  REG_STATUS   = 8'h04;
    localparam logic [7:0]  REG_DATA     = 8'h08;
    localparam logic [7:0]  REG_IRQ_STAT = 8'h0c;
    localparam logic [7:0]  REG_IRQ_CLR  = 8'h10;
    localparam logic [7:0]  REG_IRQ_EN   = 8'h14;
    localparam logic [7:0]  REG_PERIOD   = 8'h18;
    localparam int          CTRL_EN      = 0;
    localparam int          CTRL_MODE    = 1;
    localparam int          CTRL_SELF    = 2;
    localparam int          DATA_VALID   = 8;
    localparam int          IRQ_OCTET    = 0;
    localparam int          IRQ_FAIL     = 1;
    localparam int          IRQ_SELF     = 2;
    localparam int          RUN_LIM      = 32;
    localparam logic [5:0]  RUN_LAST     = 6'h1f;
    localparam logic [5:0]  DLY_FULL     = 6'h20;
    localparam logic [7:0]  WIN_LAST     = 8'hff;
    localparam logic [8:0]  ONES_LO      = 9'h060;
    localparam logic [8:0]  ONES_HI      = 9'h0a0;
    localparam logic [6:0]  SELF_LAST    = 7'h3f;
    localparam logic [15:0] PERIOD_RST   = 16'h0400;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef struct packed {
        logic self_done;
        logic self_pass;
        logic self_busy;
        logic startup_done;
        logic ol_fail;
        logic tf_fail;
        logic out_ok;
    } prhg_stat_t;

    typedef enum logic {PRHG_OL_TEST, PRHG_OL_WAIT} prhg_ol_t;
endpackage : prhg_pkg

// File: core/prhg_top.sv
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module prhg_top (
    input  wire logic        clk_sys_in,
    input  wire logic        reset_n_in,
    input  wire logic        raw_bit_in,
    input  wire logic        raw_tog_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    output logic [1:0]       s_axi_bresp_out,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    input  wire logic [7:0]  s_axi_araddr_in,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic [7:0]       rng_octet_out,
    output logic             rng_valid_out,
    output prhg_pkg::prhg_stat_t stat_out,
    output logic             irq_out
);
    import prhg_pkg::*;

    logic [2:0]  bit_s_q, tog_s_q;
    logic        tog_acc_q, bit_evt, raw_b;
    logic        en_q, mode_q, out_ok_q, tf_fail_q, ol_fail_q, start_ok_q;
    logic [15:0] period_q, wait_q;
    logic [5:0]  run_q, dly_cnt_q;
    logic        last_q, tf_hit;
    logic [RUN_LIM-1:0] dly_q;
    logic [7:0]  oct_q, out_q, win_q;
    logic [2:0]  ob_q;
    logic        oct_done;
    logic [7:0]  oct_d;
    logic [8:0]  ones_q, ones_d;
    logic        win_end, win_bad;
    prhg_ol_t    ol_q;
    logic        out_valid_q, self_busy_q, self_pass_q, self_done_q;
    logic        seen0_q, seen1_q, self_bad_q, self_go;
    logic [6:0]  self_cnt_q;
    logic [2:0]  irq_stat_q, irq_en_q, irq_set, irq_clr;
    logic        aw_have_q, w_have_q, awready_q, wready_q, arready_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        bvalid_q, rvalid_q, wr_go, rd_go, rd_data;
    logic [1:0]  bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic        out_ok_d;

    // only stage 1 and 2 are compared, stage 0 feeds stage 1 alone
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            bit_s_q   <= 3'h0;
            tog_s_q   <= 3'h0;
            tog_acc_q <= 1'b0;
        end else begin
            bit_s_q <= {bit_s_q[1:0], raw_bit_in};
            tog_s_q <= {tog_s_q[1:0], raw_tog_in};
            if (bit_evt) begin
                tog_acc_q <= tog_s_q[2];
            end
        end
    end
    assign bit_evt = (tog_s_q[1] == tog_s_q[2]) && (tog_s_q[2] != tog_acc_q);
    assign raw_b   = bit_s_q[2];

    // total failure: a run of RUN_LIM+1 equal raw bits means a stuck source
    assign tf_hit = bit_evt && en_q && (raw_b == last_q) && (run_q == RUN_LAST);
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in || !en_q) begin
            run_q  <= 6'h0;
            last_q <= 1'b0;
        end else if (bit_evt) begin
            last_q <= raw_b;
            run_q  <= (raw_b == last_q && run_q != RUN_LAST) ? run_q + 6'h1 : 6'h0;
        end
    end

    // bits age RUN_LIM positions before use, so a stuck run is caught before
    // any of its bits leaves; costs RUN_LIM bits of latency
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in || !en_q || tf_hit) begin
            dly_q     <= '0;
            dly_cnt_q <= 6'h0;
            ob_q      <= 3'h0;
            oct_q     <= 8'h0;
        end else if (bit_evt) begin
            dly_q <= {dly_q[RUN_LIM-2:0], raw_b};
            if (dly_cnt_q != DLY_FULL) begin
                dly_cnt_q <= dly_cnt_q + 6'h1;
            end else begin
                oct_q <= oct_d;
                ob_q  <= ob_q + 3'h1;
            end
        end
    end
    assign oct_d    = {oct_q[6:0], dly_q[RUN_LIM-1]};
    assign oct_done = bit_evt && en_q && !tf_hit && dly_cnt_q == DLY_FULL && ob_q == 3'h7;

    // monobit window over 256 raw bits; bounds chosen for the entropy target
    assign ones_d  = ones_q + {8'h0, raw_b};
    assign win_end = bit_evt && en_q && ol_q == PRHG_OL_TEST && win_q == WIN_LAST;
    assign win_bad = (ones_d < ONES_LO) || (ones_d > ONES_HI);
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in || !en_q) begin
            ol_q   <= PRHG_OL_TEST;
            win_q  <= 8'h0;
            ones_q <= 9'h0;
            wait_q <= 16'h0;
        end else if (bit_evt) begin
            case (ol_q)
                PRHG_OL_TEST: begin
                    win_q  <= win_q + 8'h1;
                    ones_q <= win_end ? 9'h0 : ones_d;
                    if (win_end && mode_q && start_ok_q) begin
                        ol_q   <= PRHG_OL_WAIT;
                        wait_q <= 16'h0;
                    end
                end
                PRHG_OL_WAIT: begin
                    wait_q <= wait_q + 16'h1;
                    if (!mode_q || wait_q >= period_q) begin
                        ol_q <= PRHG_OL_TEST;
                    end
                end
                default: ol_q <= PRHG_OL_TEST;
            endcase
        end else if (ol_q == PRHG_OL_WAIT && !mode_q) begin
            ol_q <= PRHG_OL_TEST;
        end
    end

    // health state; disabling the generator restarts the start-up tests
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in || !en_q) begin
            tf_fail_q  <= 1'b0;
            ol_fail_q  <= 1'b0;
            start_ok_q <= 1'b0;
        end else begin
            if (tf_hit) begin
                tf_fail_q <= 1'b1;
            end
            if (win_end) begin
                ol_fail_q <= win_bad;
                if (!win_bad && !tf_fail_q && !tf_hit) begin
                    start_ok_q <= 1'b1;
                end
            end
        end
    end

    assign out_ok_d = en_q && start_ok_q && !tf_fail_q && !ol_fail_q && !tf_hit
                      && !(win_end && win_bad);
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            out_ok_q <= 1'b0;
        end else begin
            out_ok_q <= out_ok_d;
        end
    end

    // one octet holding register; a new octet is dropped while it is unread
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            out_q       <= 8'h0;
            out_valid_q <= 1'b0;
        end else if (!out_ok_d) begin
            out_valid_q <= 1'b0;
        end else if (oct_done && out_ok_q && (!out_valid_q || rd_data)) begin
            out_q       <= oct_d;
            out_valid_q <= 1'b1;
        end else if (rd_data) begin
            out_valid_q <= 1'b0;
        end
    end

    // software-started stuck-source self-test over 64 raw bits
    assign self_go = wr_go && awaddr_q == REG_CTRL && wstrb_q[0] && wdata_q[CTRL_SELF]
                     && en_q && !self_busy_q;
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in || !en_q) begin
            self_busy_q <= 1'b0;
            self_pass_q <= 1'b0;
            self_done_q <= 1'b0;
            seen0_q     <= 1'b0;
            seen1_q     <= 1'b0;
            self_bad_q  <= 1'b0;
            self_cnt_q  <= 7'h0;
        end else if (self_go) begin
            self_busy_q <= 1'b1;
            self_done_q <= 1'b0;
            self_pass_q <= 1'b0;
            seen0_q     <= 1'b0;
            seen1_q     <= 1'b0;
            self_bad_q  <= 1'b0;
            self_cnt_q  <= 7'h0;
        end else if (self_busy_q && bit_evt) begin
            self_cnt_q <= self_cnt_q + 7'h1;
            seen0_q    <= seen0_q | !raw_b;
            seen1_q    <= seen1_q | raw_b;
            self_bad_q <= self_bad_q | tf_hit;
            if (self_cnt_q == SELF_LAST) begin
                self_busy_q <= 1'b0;
                self_done_q <= 1'b1;
                self_pass_q <= (seen0_q | !raw_b) & (seen1_q | raw_b)
                               & !self_bad_q & !tf_hit;
            end
        end
    end

    // interrupts: a set in the same cycle as a clear wins
    assign irq_set = {self_busy_q && bit_evt && self_cnt_q == SELF_LAST,
                      tf_hit || (win_end && win_bad),
                      oct_done && out_ok_q && (!out_valid_q || rd_data) && out_ok_d};
    assign irq_clr = (wr_go && awaddr_q == REG_IRQ_CLR && wstrb_q[0]) ? wdata_q[2:0] : 3'h0;
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            irq_stat_q <= 3'h0;
            irq_out    <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
            irq_out    <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_en_q);
        end
    end

    // axi4-lite write path; address and data may arrive in either order
    assign wr_go = aw_have_q && w_have_q && !bvalid_q;
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= 8'h0;
            wdata_q   <= 32'h0;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            awready_q <= s_axi_awvalid_in && !awready_q && !aw_have_q && !bvalid_q;
            wready_q  <= s_axi_wvalid_in && !wready_q && !w_have_q && !bvalid_q;
            if (s_axi_awvalid_in && awready_q) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= {s_axi_awaddr_in[7:2], 2'h0};
            end
            if (s_axi_wvalid_in && wready_q) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata_in;
                wstrb_q  <= s_axi_wstrb_in;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= (awaddr_q <= REG_PERIOD && awaddr_q != REG_STATUS
                              && awaddr_q != REG_DATA && awaddr_q != REG_IRQ_STAT)
                             ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready_in) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            en_q     <= 1'b0;
            mode_q   <= 1'b0;
            irq_en_q <= 3'h0;
            period_q <= PERIOD_RST;
        end else if (wr_go) begin
            if (awaddr_q == REG_CTRL && wstrb_q[0]) begin
                en_q   <= wdata_q[CTRL_EN];
                mode_q <= wdata_q[CTRL_MODE];
            end
            if (awaddr_q == REG_IRQ_EN && wstrb_q[0]) begin
                irq_en_q <= wdata_q[2:0];
            end
            if (awaddr_q == REG_PERIOD) begin
                if (wstrb_q[0]) period_q[7:0] <= wdata_q[7:0];
                if (wstrb_q[1]) period_q[15:8] <= wdata_q[15:8];
            end
        end
    end

    // axi4-lite read path; reading data consumes the octet
    assign rd_go   = s_axi_arvalid_in && arready_q;
    assign rd_data = rd_go && {s_axi_araddr_in[7:2], 2'h0} == REG_DATA;
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0;
            rresp_q   <= RESP_OKAY;
        end else begin
            arready_q <= s_axi_arvalid_in && !arready_q && !rvalid_q;
            if (rd_go) begin
                rvalid_q <= 1'b1;
                rresp_q  <= RESP_OKAY;
                case ({s_axi_araddr_in[7:2], 2'h0})
                    REG_CTRL:     rdata_q <= {29'h0, 1'b0, mode_q, en_q};
                    REG_STATUS:   rdata_q <= {25'h0, stat_out};
                    REG_DATA:     rdata_q <= {23'h0, out_valid_q, out_q};
                    REG_IRQ_STAT: rdata_q <= {29'h0, irq_stat_q};
                    REG_IRQ_CLR:  rdata_q <= 32'h0;
                    REG_IRQ_EN:   rdata_q <= {29'h0, irq_en_q};
                    REG_PERIOD:   rdata_q <= {16'h0, period_q};
                    default: begin
                        rdata_q <= 32'h0;
                        rresp_q <= RESP_SLVERR;
                    end
                endcase
            end else if (rvalid_q && s_axi_rready_in) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            stat_out <= '0;
        end else begin
            stat_out <= '{self_done_q, self_pass_q, self_busy_q, start_ok_q,
                          ol_fail_q, tf_fail_q, out_ok_q};
        end
    end

    assign s_axi_awready_out = awready_q;
    assign s_axi_wready_out  = wready_q;
    assign s_axi_bvalid_out  = bvalid_q;
    assign s_axi_bresp_out   = bresp_q;
    assign s_axi_arready_out = arready_q;
    assign s_axi_rvalid_out  = rvalid_q;
    assign s_axi_rdata_out   = rdata_q;
    assign s_axi_rresp_out   = rresp_q;
    assign rng_octet_out     = out_q;
    assign rng_valid_out     = out_valid_q;

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);

    property p_tf_block; tf_hit |=> tf_fail_q && !out_ok_q && !out_valid_q; endproperty
    a_tf_block: assert property (p_tf_block) else $error("stuck source not blocked");
    property p_tf_flush; tf_hit |=> dly_cnt_q == 6'h0 && ob_q == 3'h0; endproperty
    a_tf_flush: assert property (p_tf_flush) else $error("bits after failure kept");
    property p_ol_start; !start_ok_q |-> ol_q == PRHG_OL_TEST; endproperty
    a_ol_start: assert property (p_ol_start) else $error("start-up test idle");
    property p_hold; !start_ok_q || ol_fail_q |-> !out_ok_q ##1 !out_valid_q; endproperty
    a_hold: assert property (p_hold) else $error("output before test passed");
    property p_cont; ol_q == PRHG_OL_WAIT && !mode_q |=> ol_q == PRHG_OL_TEST; endproperty
    a_cont: assert property (p_cont) else $error("continuous mode paused");
    property p_octet; out_valid_q && $past(out_valid_q) && !$past(rd_data) |-> $stable(out_q);
    endproperty
    a_octet: assert property (p_octet) else $error("octet changed while held");
    property p_self_go; $rose(self_busy_q) |-> $past(self_go); endproperty
    a_self_go: assert property (p_self_go) else $error("self-test not started by sw");
    property p_self_end; $fell(self_busy_q) && en_q |-> self_done_q; endproperty
    a_self_end: assert property (p_self_end) else $error("self-test result missing");
    property p_win; win_end && win_bad |=> ol_fail_q && !out_ok_q; endproperty
    a_win: assert property (p_win) else $error("biased window not flagged");
    property p_valid; out_valid_q |-> out_ok_q; endproperty
    a_valid: assert property (p_valid) else $error("valid while withheld");

    property p_c_oct; $rose(out_valid_q); endproperty
    c_oct: cover property (p_c_oct);
    property p_c_pass; $rose(self_done_q) && self_pass_q; endproperty
    c_pass: cover property (p_c_pass);
    property p_c_tf; tf_hit; endproperty
    c_tf: cover property (p_c_tf);
endmodule : prhg_top

// File: verification/tb_physical_rng_health_gating.sv
`timescale 1ns/1ps
module tb_physical_rng_health_gating;
    import prhg_pkg::*;
    logic        clk_sys_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic        raw_bit_in = 1'b0;
    logic        raw_tog_in = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hf;
    logic        awready, wready, bvalid, arready, rvalid, rng_valid, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [7:0]  rng_octet;
    prhg_stat_t  stat;
    int          n_mismatch = 0;
    int          compares = 0;

    always #2 clk_sys_in = ~clk_sys_in;

    prhg_top dut_u (
        .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .raw_bit_in(raw_bit_in),
        .raw_tog_in(raw_tog_in), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_awaddr_in(awaddr), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .rng_octet_out(rng_octet), .rng_valid_out(rng_valid), .stat_out(stat), .irq_out(irq)
    );

    task automatic conclude;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask : cyc

    // master holds each channel until its own ready, bready until bvalid
    task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(posedge clk_sys_in);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                chk({30'h0, bresp}, {30'h0, er}, "write response");
                bready <= 1'b0;
                break;
            end
            n++;
            if (n > 100) begin
                n_mismatch++;
                conclude();
            end
        end
    endtask : wchk

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(posedge clk_sys_in);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
            n++;
            if (n > 100) begin
                n_mismatch++;
                conclude();
            end
        end
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(d, exp, "read data");
        chk({30'h0, r}, {30'h0, er}, "read response");
    endtask : rchk

    // bit is held 4 clocks each side of its toggle so the synchroniser sees it settled
    task automatic feed(input logic [7:0] pat, input int nb);
        for (int i = 0; i < nb; i++) begin
            raw_bit_in <= pat[7 - (i % 8)];
            cyc(4);
            raw_tog_in <= ~raw_tog_in;
            cyc(4);
        end
    endtask : feed

    task automatic feed_until(input logic [7:0] pat, input int b, input int lim);
        for (int k = 0; k < lim; k++) begin
            feed(pat, 8);
            cyc(8);
            if (stat[b] === 1'b1) break;
        end
        chk({31'h0, stat[b]}, 32'h1, "status bit wait");
    endtask : feed_until

    task automatic t_reset;
        chk({23'h0, irq, rng_valid, stat}, 32'h0, "outputs after reset");
        rchk(REG_CTRL, 32'h0, RESP_OKAY);
        rchk(REG_PERIOD, {16'h0, PERIOD_RST}, RESP_OKAY);
        // byte lane 0 only: the upper period byte must keep its reset value
        wstrb <= 4'h1;
        wchk(REG_PERIOD, 32'h1234, RESP_OKAY);
        wstrb <= 4'hf;
        rchk(REG_PERIOD, {16'h0, PERIOD_RST[15:8], 8'h34}, RESP_OKAY);
        wchk(REG_PERIOD, {16'h0, PERIOD_RST}, RESP_OKAY);
        rchk(REG_IRQ_EN, 32'h0, RESP_OKAY);
        rchk(8'h40, 32'h0, RESP_SLVERR);
        wchk(REG_STATUS, 32'h7f, RESP_SLVERR);
        rchk(REG_STATUS, 32'h0, RESP_OKAY);
    endtask : t_reset

    task automatic t_startup;
        wchk(REG_CTRL, 32'h1, RESP_OKAY);
        feed(8'hc3, 32);
        cyc(8);
        chk({30'h0, rng_valid, stat.startup_done}, 32'h0, "output before start-up");
        feed_until(8'hc3, 3, 80);
        chk({29'h0, stat.ol_fail, stat.tf_fail, stat.out_ok}, 32'h1, "gate open");
        feed(8'hc3, 16);
        cyc(8);
        chk({23'h0, rng_valid, rng_octet}, 32'h1c3, "octet port");
        rchk(REG_DATA, 32'h1c3, RESP_OKAY);
        cyc(2);
        chk({31'h0, rng_valid}, 32'h0, "valid after read");
    endtask : t_startup

    task automatic t_irq;
        rchk(REG_IRQ_STAT, 32'h1, RESP_OKAY);
        chk({31'h0, irq}, 32'h0, "irq masked");
        wchk(REG_IRQ_EN, 32'h1, RESP_OKAY);
        cyc(2);
        chk({31'h0, irq}, 32'h1, "irq enabled");
        wchk(REG_IRQ_CLR, 32'h1, RESP_OKAY);
        cyc(2);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        rchk(REG_IRQ_STAT, 32'h0, RESP_OKAY);
        rchk(REG_IRQ_CLR, 32'h0, RESP_OKAY);
        feed(8'hc3, 8);
        cyc(8);
        chk({31'h0, irq}, 32'h1, "irq on new octet");
        wchk(REG_IRQ_EN, 32'h2, RESP_OKAY);
        cyc(2);
        chk({31'h0, irq}, 32'h0, "octet source masked");
    endtask : t_irq

    task automatic t_tfail;
        feed(8'hff, 40);
        cyc(8);
        chk({30'h0, stat.tf_fail, stat.out_ok}, 32'h2, "total failure");
        chk({30'h0, rng_valid, irq}, 32'h1, "valid withheld, irq");
        rchk(REG_IRQ_STAT, 32'h3, RESP_OKAY);
        feed(8'hc3, 64);
        cyc(8);
        chk({30'h0, rng_valid, stat.tf_fail}, 32'h1, "failure sticky");
    endtask : t_tfail

    task automatic t_self;
        logic [31:0] d;
        logic [1:0]  r;
        wchk(REG_CTRL, 32'h0, RESP_OKAY);
        wchk(REG_CTRL, 32'h1, RESP_OKAY);
        feed(8'hc3, 64);
        cyc(8);
        chk({29'h0, stat[6:4]}, 32'h0, "no self-test unless started");
        wchk(REG_CTRL, 32'h5, RESP_OKAY);
        cyc(3);
        chk({31'h0, stat.self_busy}, 32'h1, "self-test busy");
        rchk(REG_CTRL, 32'h1, RESP_OKAY);
        feed_until(8'hc3, 6, 12);
        rd(REG_STATUS, d, r);
        chk({29'h0, d[6:4]}, 32'h6, "self-test pass");
        wchk(REG_CTRL, 32'h5, RESP_OKAY);
        feed(8'hff, 64);
        cyc(8);
        chk({29'h0, stat[6:4]}, 32'h4, "self-test fail");
        rd(REG_IRQ_STAT, d, r);
        chk({31'h0, d[2]}, 32'h1, "self-test done event");
    endtask : t_self

    task automatic t_online;
        wchk(REG_CTRL, 32'h0, RESP_OKAY);
        wchk(REG_CTRL, 32'h3, RESP_OKAY);
        rchk(REG_CTRL, 32'h3, RESP_OKAY);
        // one set bit per octet: no long runs, but far too few ones per window
        feed_until(8'h80, 2, 80);
        chk({29'h0, rng_valid, stat.startup_done, stat.out_ok}, 32'h0, "defect gate");
        feed_until(8'hc3, 3, 100);
        chk({30'h0, stat.ol_fail, stat.out_ok}, 32'h1, "recovered");
        feed(8'hc3, 16);
        cyc(8);
        chk({23'h0, rng_valid, rng_octet}, 32'h1c3, "periodic output");
        // finish the third window, then a biased stretch lands in the idle gap
        feed(8'hc3, 240);
        feed(8'h80, 256);
        cyc(8);
        chk({30'h0, stat.ol_fail, stat.out_ok}, 32'h1, "periodic idle");
        wchk(REG_CTRL, 32'h1, RESP_OKAY);
        rchk(REG_CTRL, 32'h1, RESP_OKAY);
        // continuous mode tests again at once, so the same stretch now fails
        feed(8'h80, 256);
        cyc(8);
        chk({30'h0, stat.ol_fail, stat.out_ok}, 32'h2, "continuous test");
    endtask : t_online

    initial begin
        cyc(6);
        reset_n_in <= 1'b1;
        t_reset();
        t_startup();
        t_irq();
        t_tfail();
        t_self();
        t_online();
        conclude();
    end

    initial begin
        // tests need about 16k cycles; the limit leaves room for slow status waits
        cyc(40000);
        n_mismatch++;
        conclude();
    end
endmodule : tb_physical_rng_health_gating
